// ==== verilog/rsc_pkg.sv ====
// Shared constants and types for the reset source and cause block
package rsc_pkg;
  localparam int ADDR_W = 4;
  localparam int PC_W = 16;
  // Register byte addresses
  localparam logic [3:0] ADDR_POWER_CONTROL_REG = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_CFG = 4'h8;
  localparam logic [3:0] ADDR_STATE = 4'hC;
  // Power control register bit positions
  localparam int POS_STK_OVER = 7;
  localparam int POS_STK_UNDER = 6;
  localparam int POS_PIN_RST = 3;
  localparam int POS_INSTR_RST = 2;
  localparam int POS_POR = 1;
  localparam int POS_BOR = 0;
  // Status register bit positions
  localparam int POS_TIMEOUT = 1;
  localparam int POS_POWERDOWN = 0;
  // Reset values
  localparam logic [7:0] POWER_CONTROL_REG_RST = 8'h0C;
  localparam logic [1:0] STATUS_RST = 2'h3;
  localparam logic [5:0] CFG_RST = 6'h01;
  // Program counter targets and AXI response codes
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] PC_IRQ_VECTOR = 16'h0004;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int FILTER_NS = 100;
  localparam int FILTER_CYC = (FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POWERUP_TIMER_MS = 64;
  localparam int POWERUP_TIMER_CYC = POWERUP_TIMER_MS * 1000000 / CLK_PERIOD_NS;

  typedef struct packed {
    logic osc_wait;
    logic pullup_sw;
    logic powerup_timer_enable_n;
    logic stack_fault_reset_enable;
    logic low_voltage_program_enable;
    logic ext_reset_pin_enable;
  } rsc_cfg_type;

  typedef struct packed {
    logic stack_over_flag;
    logic stack_under_flag;
    logic pin_reset_flag_n;
    logic reset_instr_flag_n;
    logic por_flag_n;
    logic bor_flag_n;
  } rsc_power_control_reg_type;
endpackage

// ==== verilog/rsc_reset_cause.sv ====
// Reset source gathering, start-up sequencing and reset cause flags
// Operation
// - Pin reset is off only when pin enable and low-voltage enable are 0.
// - While pin reset is enabled, a low pin holds the core in reset.
// - A glitch filter ignores short low pulses on the reset pin.
// - The block never drives the reset pin low.
// - Disabled pin is input with software pull-up; enabled forces pull-up.
// - Watchdog timeout resets the core when awake, wakes it from sleep, and updates timeout, powerdown flags.
// - Reset instruction resets the core and clears its flag only.
// - With stack fault reset enabled, overflow or underflow resets and flags.
// - Programming mode exit acts exactly like power-on reset.
// - Power-up timer delays start only when its enable selects it.
// - Power-up timer is 64 ms, starts after release, active-low enable.
// - Start needs timer done, oscillator ready when osc_wait is set, and enabled pin released.
// - Timers run regardless of pin; start follows pin rise at once.
// - Power-on loads PC zero, sets timeout, powerdown, flags 00 110x.
// - Timeout and powerdown flags both read 1 after power-on.
// - Brown-out loads PC zero, clears stack and brown-out flags.
// - Pin reset in run clears pin flag, loads PC zero.
// - Pin reset in sleep also sets timeout and clears powerdown.
// - Watchdog wake clears timeout and powerdown, continues at PC plus one.
// - Interrupt wake sets timeout, clears powerdown, vectors if enabled.
// - Stack resets set only their own flag and load PC zero.
// - Watchdog reset in run clears timeout flag only, loads PC zero.
// - Firmware sets power flags back to 1; hardware only clears them.
//
// Added by the designer: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module rsc_reset_cause #(
  parameter int unsigned POWERUP_TIMER_CYCLES = rsc_pkg::POWERUP_TIMER_CYC,
  parameter logic [5:0] CFG_INIT = rsc_pkg::CFG_RST
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [rsc_pkg::ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [rsc_pkg::ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic master_clear_pin_i,
  output logic master_clear_pin_o,
  output logic master_clear_pin_oe_o,
  output logic pin_pullup_o,
  output logic pin_gpio_o,
  input wire logic power_on_i,
  input wire logic brownout_reset_i,
  input wire logic prog_exit_i,
  input wire logic osc_ready_i,
  input wire logic watchdog_timeout_i,
  input wire logic watchdog_clear_instr_i,
  input wire logic reset_instr_i,
  input wire logic stack_over_i,
  input wire logic stack_under_i,
  input wire logic sleep_i,
  input wire logic irq_wake_i,
  input wire logic global_irq_enable_i,
  input wire logic [rsc_pkg::PC_W-1:0] pc_i,
  output logic core_rst_o,
  output logic pc_load_o,
  output logic [rsc_pkg::PC_W-1:0] pc_value_o,
  output logic wake_o
);
  localparam int TW = $clog2(POWERUP_TIMER_CYCLES + 1);

  initial begin
    if (POWERUP_TIMER_CYCLES < 1 || POWERUP_TIMER_CYCLES > 32'h7FFFFFFF) begin
      $error("POWERUP_TIMER_CYCLES out of range");
    end
  end

  typedef enum logic [3:0] {
    ST_POWER = 4'h1,
    ST_START = 4'h2,
    ST_RUN = 4'h4,
    ST_HOLD = 4'h8
  } rsc_state_type;

  rsc_state_type state;
  rsc_pkg::rsc_cfg_type cfg;
  rsc_pkg::rsc_power_control_reg_type power_control_reg;
  logic timeout_flag_n;
  logic powerdown_flag_n;
  logic pin_m, pin_s, por_m, por_s, por_d, bor_m, bor_s, bor_d;
  logic [7:0] low_cnt;
  logic pin_low_f;
  logic [TW-1:0] powerup_timer_cnt;
  logic aw_held, w_held;
  logic [rsc_pkg::ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_en, wr_byte;

  // Pin, power-on and brown-out levels cross into the core clock
  always_ff @(posedge clk_i) begin
    pin_m <= master_clear_pin_i;
    pin_s <= pin_m;
    por_m <= power_on_i;
    por_s <= por_m;
    bor_m <= brownout_reset_i;
    bor_s <= bor_m;
    por_d <= por_s;
    bor_d <= bor_s;
  end

  // Filter only delays assertion, so release is seen at once
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || pin_s) begin
      low_cnt <= 8'h00;
      pin_low_f <= 1'b0;
    end else if (low_cnt >= 8'(rsc_pkg::FILTER_CYC - 1)) begin
      pin_low_f <= 1'b1;
    end else begin
      low_cnt <= low_cnt + 8'h01;
    end
  end

  logic pin_en, run, power_evt, bor_evt, pin_evt, wdt_evt, instr_evt;
  logic ovf_evt, unf_evt, irq_evt, int_req, start_ok, pin_hold;
  assign pin_en = cfg.ext_reset_pin_enable
    | cfg.low_voltage_program_enable;
  assign pin_hold = pin_en & pin_low_f;
  assign run = state == ST_RUN;
  assign power_evt = (por_s & ~por_d) | prog_exit_i;
  assign bor_evt = bor_s & ~bor_d & ~por_s;
  assign pin_evt = run & pin_hold;
  assign wdt_evt = run & watchdog_timeout_i;
  assign instr_evt = run & reset_instr_i;
  assign ovf_evt = run & cfg.stack_fault_reset_enable & stack_over_i;
  assign unf_evt = run & cfg.stack_fault_reset_enable & stack_under_i;
  assign irq_evt = run & sleep_i & irq_wake_i & ~watchdog_timeout_i;
  assign int_req = (wdt_evt & ~sleep_i) | instr_evt | ovf_evt | unf_evt;
  assign start_ok = (cfg.powerup_timer_enable_n || powerup_timer_cnt == '0)
    && (!cfg.osc_wait || osc_ready_i) && !pin_hold;

  // Sequencer; power events outrank every other source
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state <= ST_POWER;
    end else if (power_evt || bor_evt || por_s || bor_s) begin
      state <= ST_POWER;
    end else begin
      unique case (state)
        ST_POWER: begin
          state <= ST_START;
        end
        ST_START: begin
          if (start_ok) begin
            state <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (pin_evt || int_req) begin
            state <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (!pin_hold) begin
            state <= ST_RUN;
          end
        end
      endcase
    end
  end

  // Timer starts once power-on and brown-out are released
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || state == ST_POWER) begin
      powerup_timer_cnt <= TW'(POWERUP_TIMER_CYCLES);
    end else if (state == ST_START && powerup_timer_cnt != '0) begin
      powerup_timer_cnt <= powerup_timer_cnt - TW'(1);
    end
  end

  // Program counter target; a wake does not reset the core
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pc_load_o <= 1'b0;
      pc_value_o <= rsc_pkg::PC_RESET;
      wake_o <= 1'b0;
    end else begin
      pc_load_o <= 1'b0;
      wake_o <= 1'b0;
      if ((state == ST_START && start_ok && !por_s && !bor_s)
          || (state == ST_HOLD && !pin_hold && !por_s && !bor_s)) begin
        pc_load_o <= 1'b1;
        pc_value_o <= rsc_pkg::PC_RESET;
      end else if (!power_evt && !bor_evt && !por_s && !bor_s
                   && run && sleep_i && (wdt_evt || irq_evt)) begin
        pc_load_o <= 1'b1;
        wake_o <= 1'b1;
        if (irq_evt && global_irq_enable_i) begin
          pc_value_o <= rsc_pkg::PC_IRQ_VECTOR;
        end else begin
          pc_value_o <= pc_i + 16'h0001;
        end
      end
    end
  end

  // Cause flags: software write first, hardware events last so they win
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      power_control_reg <= rsc_pkg::rsc_power_control_reg_type'({rsc_pkg::POWER_CONTROL_REG_RST[7:6],
                              rsc_pkg::POWER_CONTROL_REG_RST[3:0]});
      timeout_flag_n <= rsc_pkg::STATUS_RST[rsc_pkg::POS_TIMEOUT];
      powerdown_flag_n <= rsc_pkg::STATUS_RST[rsc_pkg::POS_POWERDOWN];
    end else begin
      if (wr_byte && aw_addr == rsc_pkg::ADDR_POWER_CONTROL_REG) begin
        power_control_reg <= rsc_pkg::rsc_power_control_reg_type'({w_data[rsc_pkg::POS_STK_OVER],
          w_data[rsc_pkg::POS_STK_UNDER], w_data[rsc_pkg::POS_PIN_RST],
          w_data[rsc_pkg::POS_INSTR_RST], w_data[rsc_pkg::POS_POR],
          w_data[rsc_pkg::POS_BOR]});
      end
      if (wr_byte && aw_addr == rsc_pkg::ADDR_STATUS) begin
        timeout_flag_n <= w_data[rsc_pkg::POS_TIMEOUT];
        powerdown_flag_n <= w_data[rsc_pkg::POS_POWERDOWN];
      end
      if (watchdog_clear_instr_i && run) begin
        timeout_flag_n <= 1'b1;
        powerdown_flag_n <= 1'b1;
      end
      if (power_evt) begin
        power_control_reg.stack_over_flag <= 1'b0;
        power_control_reg.stack_under_flag <= 1'b0;
        power_control_reg.pin_reset_flag_n <= 1'b1;
        power_control_reg.reset_instr_flag_n <= 1'b1;
        power_control_reg.por_flag_n <= 1'b0;
        timeout_flag_n <= 1'b1;
        powerdown_flag_n <= 1'b1;
      end else if (bor_evt) begin
        power_control_reg.stack_over_flag <= 1'b0;
        power_control_reg.stack_under_flag <= 1'b0;
        power_control_reg.pin_reset_flag_n <= 1'b1;
        power_control_reg.reset_instr_flag_n <= 1'b1;
        power_control_reg.bor_flag_n <= 1'b0;
        timeout_flag_n <= 1'b1;
        powerdown_flag_n <= 1'b1;
      end else begin
        if (pin_evt) begin
          power_control_reg.pin_reset_flag_n <= 1'b0;
          if (sleep_i) begin
            timeout_flag_n <= 1'b1;
            powerdown_flag_n <= 1'b0;
          end
        end
        if (wdt_evt) begin
          timeout_flag_n <= 1'b0;
          if (sleep_i) begin
            powerdown_flag_n <= 1'b0;
          end
        end
        if (irq_evt) begin
          timeout_flag_n <= 1'b1;
          powerdown_flag_n <= 1'b0;
        end
        if (instr_evt) begin
          power_control_reg.reset_instr_flag_n <= 1'b0;
        end
        if (ovf_evt) begin
          power_control_reg.stack_over_flag <= 1'b1;
        end
        if (unf_evt) begin
          power_control_reg.stack_under_flag <= 1'b1;
        end
      end
    end
  end

  // Configuration survives the resets that this block itself issues
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cfg <= rsc_pkg::rsc_cfg_type'(CFG_INIT);
    end else if (wr_byte && aw_addr == rsc_pkg::ADDR_CFG) begin
      cfg <= rsc_pkg::rsc_cfg_type'(w_data[5:0]);
    end
  end

  // Write channel: address and data are taken in either order
  assign s_axi_awready_o = !aw_held && !s_axi_bvalid_o;
  assign s_axi_wready_o = !w_held && !s_axi_bvalid_o;
  assign wr_en = aw_held && w_held && !s_axi_bvalid_o;
  assign wr_byte = wr_en && w_strb[0];

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= rsc_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata_i;
        w_strb <= s_axi_wstrb_i;
      end
      if (wr_en) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        if (aw_addr == rsc_pkg::ADDR_POWER_CONTROL_REG || aw_addr == rsc_pkg::ADDR_STATUS
            || aw_addr == rsc_pkg::ADDR_CFG) begin
          s_axi_bresp_o <= rsc_pkg::RESP_OKAY;
        end else begin
          s_axi_bresp_o <= rsc_pkg::RESP_SLVERR;
        end
      end else if (s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
    end
  end

  // Read channel, one register word per address
  assign s_axi_arready_o = !s_axi_rvalid_o;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h00000000;
      s_axi_rresp_o <= rsc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rresp_o <= rsc_pkg::RESP_OKAY;
      s_axi_rdata_o <= 32'h00000000;
      unique case (s_axi_araddr_i)
        rsc_pkg::ADDR_POWER_CONTROL_REG: begin
          s_axi_rdata_o[7:6] <= {power_control_reg.stack_over_flag, power_control_reg.stack_under_flag};
          s_axi_rdata_o[3:0] <= {power_control_reg.pin_reset_flag_n,
            power_control_reg.reset_instr_flag_n, power_control_reg.por_flag_n, power_control_reg.bor_flag_n};
        end
        rsc_pkg::ADDR_STATUS: begin
          s_axi_rdata_o[1:0] <= {timeout_flag_n, powerdown_flag_n};
        end
        rsc_pkg::ADDR_CFG: begin
          s_axi_rdata_o[5:0] <= cfg;
        end
        rsc_pkg::ADDR_STATE: begin
          s_axi_rdata_o[5:0] <= {pin_en, core_rst_o, state};
        end
        default: begin
          s_axi_rresp_o <= rsc_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

  assign core_rst_o = !run;
  assign master_clear_pin_o = 1'b0;
  assign master_clear_pin_oe_o = 1'b0;
  assign pin_pullup_o = pin_en | cfg.pullup_sw;
  assign pin_gpio_o = pin_s;

  chk_pin_undriven: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !master_clear_pin_oe_o) else $error("reset pin driven");
  chk_pullup_forced: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    pin_en |-> pin_pullup_o) else $error("pull-up off while pin reset on");
  chk_pin_disabled: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    run && !pin_en && !int_req && !power_evt && !bor_evt && !por_s
    && !bor_s |=> run) else $error("disabled pin reset the core");
  chk_filter_length: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(pin_low_f) |-> !$past(pin_s, 9) && !pin_s)
    else $error("short pulse passed filter");
  chk_pin_holds: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    pin_hold |=> core_rst_o) else $error("core runs while pin held");
  chk_por_flags: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    power_evt |=> timeout_flag_n && powerdown_flag_n && !power_control_reg.por_flag_n
    && !power_control_reg.stack_over_flag && core_rst_o) else $error("power-on flags wrong");
  chk_bor_flags: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    bor_evt && !power_evt |=> !power_control_reg.bor_flag_n && power_control_reg.pin_reset_flag_n
    && power_control_reg.reset_instr_flag_n && !power_control_reg.stack_under_flag)
    else $error("brown-out flags wrong");
  chk_instr_flag: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    instr_evt && !power_evt && !bor_evt |=> !power_control_reg.reset_instr_flag_n
    && $stable(power_control_reg.pin_reset_flag_n) && state == ST_HOLD)
    else $error("reset instruction not recorded");
  chk_stack_reset: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ovf_evt && !power_evt && !bor_evt |=> power_control_reg.stack_over_flag && core_rst_o
    ##1 pc_load_o && pc_value_o == rsc_pkg::PC_RESET)
    else $error("stack overflow reset wrong");
  chk_powerup_timer_wait: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    state == ST_START && !cfg.powerup_timer_enable_n && powerup_timer_cnt > TW'(1)
    |=> !run) else $error("start before power-up timer");
  chk_wdt_wake: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    wdt_evt && sleep_i && !power_evt && !bor_evt && !por_s && !bor_s
    |=> wake_o && pc_value_o == $past(pc_i) + 16'h0001 && !timeout_flag_n
    && !powerdown_flag_n) else $error("watchdog wake wrong");
endmodule

// ==== verif/rsc_pin_model.sv ====
// Model of the board-side driver of the external reset pin
`timescale 1ns/1ps
module rsc_pin_model (
  input wire logic clk_i,
  input wire logic hold_low_i,
  input wire logic drive_i,
  input wire logic drive_oe_i,
  input wire logic pullup_i,
  output logic pin_o
);
  // A floating pin toggles so that a stale level is never mistaken for data
  logic toggle = 1'b0;

  always @(posedge clk_i) begin
    toggle <= ~toggle;
  end

  always_comb begin
    if (drive_oe_i) begin
      pin_o = drive_i;
    end else if (hold_low_i) begin
      pin_o = 1'b0;
    end else if (pullup_i) begin
      pin_o = 1'b1;
    end else begin
      pin_o = toggle;
    end
  end
endmodule

// ==== verif/tb_rsc_reset_cause.sv ====
// Self-checking bench for the reset source and cause block
`timescale 1ns/1ps
module tb_rsc_reset_cause;
  localparam int POWERUP_TIMER = 20;
  logic clk_i = 1'b0, sys_rst_i = 1'b1, hold_low = 1'b0;
  logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0;
  logic s_axi_bready_i = 1'b0, s_axi_arvalid_i = 1'b0;
  logic s_axi_rready_i = 1'b0, power_on_i = 1'b0, brownout_reset_i = 1'b0;
  logic osc_ready_i = 1'b1, sleep_i = 1'b0, global_irq_enable_i = 1'b0;
  logic [3:0] s_axi_awaddr_i = 4'h0, s_axi_araddr_i = 4'h0;
  logic [3:0] s_axi_wstrb_i = 4'hF;
  logic [31:0] s_axi_wdata_i = 32'h0;
  logic [15:0] pc_i = 16'h0000;
  // Event pulses: watchdog, clear, instr, over, under, irq, prog exit
  logic [6:0] ev = 7'h00;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
  logic s_axi_rvalid_o, master_clear_pin_i, master_clear_pin_o;
  logic master_clear_pin_oe_o, pin_pullup_o, pin_gpio_o, core_rst_o;
  logic pc_load_o, wake_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, resp;
  logic [31:0] s_axi_rdata_o;
  logic [15:0] pc_value_o;
  int failures = 0, n_checks = 0, n;

  always #5 clk_i = ~clk_i;

  rsc_reset_cause #(.POWERUP_TIMER_CYCLES(POWERUP_TIMER)) DUT (.clk_i, .sys_rst_i,
    .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i,
    .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o,
    .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i,
    .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o,
    .s_axi_rready_i, .master_clear_pin_i, .master_clear_pin_o,
    .master_clear_pin_oe_o, .pin_pullup_o, .pin_gpio_o, .power_on_i,
    .brownout_reset_i, .prog_exit_i(ev[6]), .osc_ready_i,
    .watchdog_timeout_i(ev[0]), .watchdog_clear_instr_i(ev[1]),
    .reset_instr_i(ev[2]), .stack_over_i(ev[3]), .stack_under_i(ev[4]),
    .sleep_i, .irq_wake_i(ev[5]), .global_irq_enable_i, .pc_i, .core_rst_o,
    .pc_load_o, .pc_value_o, .wake_o);

  rsc_pin_model PIN (.clk_i, .hold_low_i(hold_low),
    .drive_i(master_clear_pin_o), .drive_oe_i(master_clear_pin_oe_o),
    .pullup_i(pin_pullup_o), .pin_o(master_clear_pin_i));

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic give_up(input string nm);
    failures++;
    $display("mismatch %s expected done seen timeout", nm);
    end_of_test();
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk_i);
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    int i;
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk_i);
      if (s_axi_awvalid_i && s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wvalid_i && s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
      if (s_axi_bvalid_o === 1'b1) begin
        r = s_axi_bresp_o;
        s_axi_bready_i <= 1'b0;
        break;
      end
    end
    if (i == 50) give_up("write");
    @(posedge clk_i);
  endtask

  task automatic rdc(input string nm, input logic [3:0] a,
                     input logic [31:0] exp);
    int i;
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk_i);
      if (s_axi_arvalid_i && s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
      if (s_axi_rvalid_o === 1'b1) begin
        check(nm, s_axi_rdata_o, exp);
        check(nm, 32'(s_axi_rresp_o), 32'(rsc_pkg::RESP_OKAY));
        s_axi_rready_i <= 1'b0;
        break;
      end
    end
    if (i == 50) give_up("read");
    @(posedge clk_i);
  endtask

  task automatic pwr(input string nm, input logic [31:0] exp);
    rdc(nm, rsc_pkg::ADDR_POWER_CONTROL_REG, exp);
  endtask

  task automatic stat(input string nm, input logic [31:0] exp);
    rdc(nm, rsc_pkg::ADDR_STATUS, exp);
  endtask

  task automatic evp(input logic [6:0] m);
    ev <= m;
    @(posedge clk_i);
    ev <= 7'h00;
  endtask

  task automatic wait_load(input string nm, input logic [15:0] pc,
                           input logic wk);
    int i;
    for (i = 0; i < 60; i++) begin
      @(posedge clk_i);
      if (pc_load_o === 1'b1) break;
    end
    if (i == 60) give_up(nm);
    check(nm, 32'(pc_value_o), 32'(pc));
    check(nm, 32'(wake_o), 32'(wk));
    @(posedge clk_i);
  endtask

  // Counts edges until the core leaves reset
  task automatic wait_run(input int lim, output int k);
    for (k = 0; k < lim; k++) begin
      @(posedge clk_i);
      if (core_rst_o === 1'b0) break;
    end
    if (k == lim) give_up("start");
  endtask

  initial begin
    repeat (100000) @(posedge clk_i);
    give_up("run");
  end

  initial begin
    logic en;
    repeat (5) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    wait_run(POWERUP_TIMER + 30, n);
    check("start delay", 32'(n >= POWERUP_TIMER), 32'h1);
    pwr("flags", 32'h0C);
    stat("status", 32'h3);
    rdc("state", rsc_pkg::ADDR_STATE, 32'h24);
    wr(rsc_pkg::ADDR_STATE, 32'h0, resp);
    check("ro write", 32'(resp), 32'(rsc_pkg::RESP_SLVERR));
    wr(4'h2, 32'h0, resp);
    check("unmapped", 32'(resp), 32'(rsc_pkg::RESP_SLVERR));
    hold_low <= 1'b1;
    cyc(5);
    hold_low <= 1'b0;
    cyc(20);
    check("glitch", 32'(core_rst_o), 32'h0);
    hold_low <= 1'b1;
    cyc(40);
    check("pin hold", 32'(core_rst_o), 32'h1);
    check("pin oe", 32'(master_clear_pin_oe_o), 32'h0);
    check("pin drive", 32'(master_clear_pin_o), 32'h0);
    hold_low <= 1'b0;
    wait_load("pin reset", rsc_pkg::PC_RESET, 1'b0);
    pwr("pin flags", 32'h04);
    stat("pin status", 32'h3);
    // Hardware only clears, so firmware must set the flags again
    wr(rsc_pkg::ADDR_POWER_CONTROL_REG, 32'h0F, resp);
    pwr("fw set", 32'h0F);
    evp(7'h04);
    wait_load("instr", rsc_pkg::PC_RESET, 1'b0);
    pwr("instr flags", 32'h0B);
    stat("instr status", 32'h3);
    evp(7'h01);
    wait_load("watchdog", rsc_pkg::PC_RESET, 1'b0);
    stat("watchdog status", 32'h1);
    pwr("watchdog flags", 32'h0B);
    evp(7'h02);
    cyc(3);
    stat("clear status", 32'h3);
    evp(7'h08);
    cyc(10);
    pwr("stack off", 32'h0B);
    wr(rsc_pkg::ADDR_CFG, 32'h05, resp);
    evp(7'h08);
    wait_load("over", rsc_pkg::PC_RESET, 1'b0);
    pwr("over flags", 32'h8B);
    evp(7'h10);
    wait_load("under", rsc_pkg::PC_RESET, 1'b0);
    pwr("under flags", 32'hCB);
    stat("stack status", 32'h3);
    sleep_i <= 1'b1;
    hold_low <= 1'b1;
    cyc(30);
    hold_low <= 1'b0;
    wait_load("sleep pin", rsc_pkg::PC_RESET, 1'b0);
    stat("sleep pin status", 32'h2);
    pwr("sleep pin flags", 32'hC3);
    pc_i <= 16'h1234;
    evp(7'h01);
    wait_load("watchdog wake", 16'h1235, 1'b1);
    stat("watchdog wake status", 32'h0);
    evp(7'h20);
    wait_load("irq wake", 16'h1235, 1'b1);
    stat("irq wake status", 32'h2);
    global_irq_enable_i <= 1'b1;
    evp(7'h20);
    wait_load("irq vector", rsc_pkg::PC_IRQ_VECTOR, 1'b1);
    sleep_i <= 1'b0;
    global_irq_enable_i <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      en = (i & 3) != 0;
      wr(rsc_pkg::ADDR_CFG, 32'((i & 3) | ((i & 4) << 2)), resp);
      rdc("pin enable", rsc_pkg::ADDR_STATE, {26'h0, en, 5'h04});
      check("pullup", 32'(pin_pullup_o), 32'(en | i[2]));
      if (!en) begin
        hold_low <= 1'b1;
        cyc(20);
        check("pin off", 32'(core_rst_o), 32'h0);
        check("gpio", 32'(pin_gpio_o), 32'h0);
        hold_low <= 1'b0;
        cyc(2);
      end
    end
    wr(rsc_pkg::ADDR_POWER_CONTROL_REG, 32'h0F, resp);
    wr(rsc_pkg::ADDR_CFG, 32'h09, resp);
    brownout_reset_i <= 1'b1;
    cyc(6);
    check("brownout hold", 32'(core_rst_o), 32'h1);
    brownout_reset_i <= 1'b0;
    wait_run(POWERUP_TIMER + 30, n);
    check("no timer", 32'(n < POWERUP_TIMER), 32'h1);
    pwr("brownout flags", 32'h0E);
    stat("brownout status", 32'h3);
    wr(rsc_pkg::ADDR_CFG, 32'h21, resp);
    osc_ready_i <= 1'b0;
    hold_low <= 1'b1;
    power_on_i <= 1'b1;
    cyc(6);
    power_on_i <= 1'b0;
    cyc(POWERUP_TIMER + 20);
    check("osc wait", 32'(core_rst_o), 32'h1);
    osc_ready_i <= 1'b1;
    cyc(20);
    check("pin wait", 32'(core_rst_o), 32'h1);
    hold_low <= 1'b0;
    wait_run(14, n);
    check("pin release", 32'(n < 6), 32'h1);
    wr(rsc_pkg::ADDR_CFG, 32'h01, resp);
    wr(rsc_pkg::ADDR_POWER_CONTROL_REG, 32'hCF, resp);
    wr(rsc_pkg::ADDR_STATUS, 32'h0, resp);
    evp(7'h40);
    wait_run(POWERUP_TIMER + 30, n);
    check("exit delay", 32'(n >= POWERUP_TIMER), 32'h1);
    pwr("exit flags", 32'h0D);
    stat("exit status", 32'h3);
    end_of_test();
  end
endmodule
